/* rtl/mcu_alu.sv */
// instruction-subset datapath of an 8-bit core with apb access
`default_nettype none
module mcu_alu
    import mcu_alu_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             osc_run,
    output logic             sleep_active
);

    // subtract b from a: {half carry, carry, result}, carry = no borrow
    function automatic logic [9:0] sub8(input logic [7:0] a,
                                        input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        return {low[4], full[8], full[7:0]};
    endfunction

    // zero test on an 8-bit result
    function automatic logic is_zero(input logic [7:0] v);
        return v == BYTE_ZERO;
    endfunction

    mcu_alu_state_type state_r, state_nxt;
    logic [7:0]  acc_r, acc_nxt;
    logic        c_r, c_nxt;
    logic        dc_r, dc_nxt;
    logic        z_r, z_nxt;
    logic        pd_r, pd_nxt;
    logic        to_r, to_nxt;
    logic [7:0]  wdt_r, wdt_nxt;
    logic [7:0]  pre_r, pre_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        osc_r, osc_nxt;
    logic [7:0]  file_mem [128];
    logic        mem_we;
    logic [6:0]  mem_wa;
    logic [7:0]  mem_wd;

    // bus phase and decoded request
    logic        setup;
    logic        commit;
    logic        wr;
    logic        in_win;
    logic        mapped;
    logic [6:0]  bus_f;
    logic [2:0]  op;
    logic        dest;
    logic [6:0]  ins_f;
    logic [7:0]  lit;
    logic [7:0]  fval;
    logic [9:0]  diff;
    logic [7:0]  res;
    logic [31:0] status_word;

    assign setup  = psel & ~penable;
    assign commit = psel & penable & pready_r;
    assign wr     = commit & pwrite;
    assign in_win = paddr[11:WIN_LSB] == FILE_SEL;
    assign bus_f  = paddr[FA_LSB +: 7];
    assign mapped = in_win | paddr == OFS_INSTR | paddr == OFS_ACC
                  | paddr == OFS_STATUS | paddr == OFS_WDOG
                  | paddr == OFS_WAKE;
    assign op     = pwdata[INS_OP_LSB +: 3];
    assign dest   = pwdata[INS_D_BIT];
    assign ins_f  = pwdata[INS_F_LSB +: 7];
    assign lit    = pwdata[INS_K_LSB +: 8];
    assign fval   = file_mem[ins_f];

    // status word as software sees it
    always_comb begin
        status_word         = WORD_ZERO;
        status_word[ST_C]   = c_r;
        status_word[ST_DC]  = dc_r;
        status_word[ST_Z]   = z_r;
        status_word[ST_PD]  = pd_r;
        status_word[ST_TO]  = to_r;
        status_word[ST_SLP] = state_r == ST_SLEEP;
    end

    // bus handshake: answer registered in the setup cycle
    always_comb begin
        pready_nxt  = setup;
        pslverr_nxt = 1'b0;
        prdata_nxt  = prdata_r;
        if (setup) begin
            prdata_nxt  = WORD_ZERO;
            pslverr_nxt = ~mapped;
            // an instruction sent while asleep is refused
            if (pwrite && paddr == OFS_INSTR && state_r == ST_SLEEP) begin
                pslverr_nxt = 1'b1;
            end
            if (!pwrite && in_win) begin
                prdata_nxt[7:0] = file_mem[bus_f];
            end else if (!pwrite) begin
                case (paddr)
                    OFS_ACC:    prdata_nxt[7:0] = acc_r;
                    OFS_STATUS: prdata_nxt = status_word;
                    OFS_WDOG: begin
                        prdata_nxt[WD_CNT_LSB +: 8] = wdt_r;
                        prdata_nxt[WD_PRE_LSB +: 8] = pre_r;
                    end
                    default:    prdata_nxt = WORD_ZERO;
                endcase
            end
        end
    end

    // instruction execution, watchdog and power state
    always_comb begin
        state_nxt = state_r;
        acc_nxt   = acc_r;
        c_nxt     = c_r;
        dc_nxt    = dc_r;
        z_nxt     = z_r;
        pd_nxt    = pd_r;
        to_nxt    = to_r;
        wdt_nxt   = wdt_r;
        pre_nxt   = pre_r;
        osc_nxt   = state_r == ST_RUN;
        mem_we    = 1'b0;
        mem_wa    = bus_f;
        mem_wd    = pwdata[7:0];
        diff      = 10'h000;
        res       = BYTE_ZERO;
        // watchdog runs only while the oscillator runs
        if (state_r == ST_RUN) begin
            pre_nxt = pre_r + BYTE_ONE;
            // counter steps when the prescaler wraps from all ones
            if (&pre_r) begin
                wdt_nxt = wdt_r + BYTE_ONE;
            end
        end
        if (wr && in_win) begin
            mem_we = 1'b1;
        end else if (wr && paddr == OFS_ACC) begin
            acc_nxt = pwdata[7:0];
        end else if (wr && paddr == OFS_STATUS) begin
            c_nxt  = pwdata[ST_C];
            dc_nxt = pwdata[ST_DC];
            z_nxt  = pwdata[ST_Z];
        end else if (wr && paddr == OFS_WAKE) begin
            state_nxt = ST_RUN;
            osc_nxt   = 1'b1;
        end else if (wr && paddr == OFS_INSTR && state_r == ST_RUN) begin
            mem_wa = ins_f;
            // one-cycle commit at the accepting edge
            case (op)
                OPC_SLEEP: begin
                    wdt_nxt   = WDT_CLEAR;
                    pre_nxt   = PRE_CLEAR;
                    pd_nxt    = 1'b0;
                    to_nxt    = 1'b1;
                    state_nxt = ST_SLEEP;
                    osc_nxt   = 1'b0;
                end
                OPC_SUBLIT: begin
                    diff    = sub8(lit, acc_r);
                    acc_nxt = diff[7:0];
                    c_nxt   = diff[8];
                    dc_nxt  = diff[9];
                    z_nxt   = is_zero(diff[7:0]);
                end
                OPC_SUBF: begin
                    diff   = sub8(fval, acc_r);
                    res    = diff[7:0];
                    c_nxt  = diff[8];
                    dc_nxt = diff[9];
                    z_nxt  = is_zero(res);
                end
                OPC_RRC: begin
                    res   = {c_r, fval[7:1]};
                    c_nxt = fval[0];
                end
                OPC_SWAP: begin
                    res = {fval[3:0], fval[7:4]};
                end
                OPC_XORLIT: begin
                    acc_nxt = acc_r ^ lit;
                    z_nxt   = is_zero(acc_r ^ lit);
                end
                OPC_XORF: begin
                    res   = acc_r ^ fval;
                    z_nxt = is_zero(res);
                end
                default: begin
                    res = BYTE_ZERO;
                end
            endcase
            // destination select for the file-register forms
            if (op == OPC_SUBF || op == OPC_RRC || op == OPC_SWAP
                || op == OPC_XORF) begin
                if (dest) begin
                    mem_we = 1'b1;
                    mem_wd = res;
                end else begin
                    acc_nxt = res;
                end
            end
        end
    end

    // control and bus registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ST_RUN;
            acc_r     <= BYTE_ZERO;
            c_r       <= 1'b0;
            dc_r      <= 1'b0;
            z_r       <= 1'b0;
            pd_r      <= PD_RST;
            to_r      <= TO_RST;
            wdt_r     <= WDT_CLEAR;
            pre_r     <= PRE_CLEAR;
            prdata_r  <= WORD_ZERO;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            osc_r     <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            acc_r     <= acc_nxt;
            c_r       <= c_nxt;
            dc_r      <= dc_nxt;
            z_r       <= z_nxt;
            pd_r      <= pd_nxt;
            to_r      <= to_nxt;
            wdt_r     <= wdt_nxt;
            pre_r     <= pre_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            osc_r     <= osc_nxt;
        end
    end

    // file register array, no reset
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            file_mem[mem_wa] <= mem_wd;
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign osc_run      = osc_r;
    assign sleep_active = state_r == ST_SLEEP;

endmodule // mcu_alu
`default_nettype wire

/* rtl/mcu_alu_pkg.sv */
// constants shared by the instruction-subset datapath
`default_nettype none
package mcu_alu_pkg;
    // apb byte offsets
    localparam logic [11:0] OFS_INSTR  = 12'h000;
    localparam logic [11:0] OFS_ACC    = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_WDOG   = 12'h00C;
    localparam logic [11:0] OFS_WAKE   = 12'h010;
    // file window: paddr[11:9] == 1 selects byte f = paddr[8:2]
    localparam logic [2:0]  FILE_SEL   = 3'h1;
    localparam int          WIN_LSB    = 9;
    localparam int          FA_LSB     = 2;
    // instruction word fields
    localparam int          INS_OP_LSB = 0;
    localparam int          INS_D_BIT  = 3;
    localparam int          INS_F_LSB  = 4;
    localparam int          INS_K_LSB  = 16;
    // opcodes
    localparam logic [2:0]  OPC_SLEEP  = 3'h0;
    localparam logic [2:0]  OPC_SUBLIT = 3'h1;
    localparam logic [2:0]  OPC_SUBF   = 3'h2;
    localparam logic [2:0]  OPC_RRC    = 3'h3;
    localparam logic [2:0]  OPC_SWAP   = 3'h4;
    localparam logic [2:0]  OPC_XORLIT = 3'h5;
    localparam logic [2:0]  OPC_XORF   = 3'h6;
    // status bit positions
    localparam int          ST_C       = 0;
    localparam int          ST_DC      = 1;
    localparam int          ST_Z       = 2;
    localparam int          ST_PD      = 3;
    localparam int          ST_TO      = 4;
    localparam int          ST_SLP     = 5;
    // watchdog bits in its register
    localparam int          WD_CNT_LSB = 0;
    localparam int          WD_PRE_LSB = 8;
    // reset and clear values
    localparam logic [7:0]  WDT_CLEAR  = 8'h00;
    localparam logic [7:0]  PRE_CLEAR  = 8'h00;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [7:0]  BYTE_ONE   = 8'h01;
    localparam logic        PD_RST     = 1'b1;
    localparam logic        TO_RST     = 1'b1;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
    // core power state
    typedef enum logic {ST_RUN, ST_SLEEP} mcu_alu_state_type;
endpackage
`default_nettype wire

/* verif/mcu_alu_monitor.sv */
// port checker of the apb access and sleep behaviour of the datapath
`default_nettype none
module mcu_alu_monitor
    import mcu_alu_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        osc_run,
    input wire logic        sleep_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_ack;
    logic wr_ack;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // acknowledged read and write access cycles
    assign rd_ack = psel && penable && pready && !pwrite;
    assign wr_ack = psel && penable && pready && pwrite;
    // a sleep instruction issued while running
    sequence s_sleep_req;
        psel && !penable && pwrite && paddr == OFS_INSTR
            && pwdata[2:0] == OPC_SLEEP && !sleep_active;
    endsequence
    sequence s_sleep_cmd;
        s_sleep_req ##1 wr_ack;
    endsequence
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    AST_PREADY_ONLY: assert property (pready |-> psel && penable
        && $past(psel && !penable)) else $error("stray pready");
    AST_SLEEP_ENTER: assert property (s_sleep_cmd |=> sleep_active
        && !osc_run) else $error("sleep not entered");
    AST_OSC_PAIR: assert property (osc_run != sleep_active)
        else $error("oscillator runs while asleep");
    AST_SLEEP_HOLD: assert property (sleep_active
        && !(wr_ack && paddr == OFS_WAKE) |=> sleep_active)
        else $error("sleep left without wake");
    AST_SLEEP_FLAGS: assert property (rd_ack && paddr == OFS_STATUS
        && sleep_active |-> prdata[5:3] == 3'h6)
        else $error("power flags wrong while asleep");
    AST_WDOG_CLEAR: assert property (rd_ack && paddr == OFS_WDOG
        && sleep_active |-> prdata[15:0] == 16'h0000)
        else $error("watchdog not cleared in sleep");
    AST_INSTR_REFUSE: assert property (psel && !penable && pwrite
        && paddr == OFS_INSTR && sleep_active |=> pslverr)
        else $error("instruction accepted while asleep");
endmodule // mcu_alu_monitor
bind mcu_alu mcu_alu_monitor mon_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_run,
    .sleep_active);
`default_nettype wire

/* verif/tb_mcu_alu.sv */
// self-checking bench of the instruction-subset datapath
`default_nettype none
module tb_mcu_alu
    import mcu_alu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc_run;
    logic        sleep_active;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          total_checks = 0;
    // 100 MHz clock
    always #5 pclk = ~pclk;
    mcu_alu dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .osc_run, .sleep_active);
    // verdict and end of run
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // compare one value
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, bounded wait for pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            end_of_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // load operands, execute, read back acc, file byte and flags
    task automatic run_op(input logic [2:0] op, input logic d,
        input logic [6:0] f, input logic [7:0] k, a, v,
        input logic [2:0] st);
        logic [7:0] r;
        logic [7:0] x;
        logic       c;
        logic       dc;
        logic       z;
        logic       to_f;
        apb(1'b1, OFS_ACC, {24'h000000, a});
        apb(1'b1, {FILE_SEL, f, 2'h0}, {24'h000000, v});
        apb(1'b1, OFS_STATUS, {29'h00000000, st});
        {z, dc, c} = st;
        x = (op == OPC_SUBLIT || op == OPC_XORLIT) ? k : v;
        to_f = d && op != OPC_SUBLIT && op != OPC_XORLIT;
        r = {x[3:0], x[7:4]};
        if (op == OPC_SUBLIT || op == OPC_SUBF) begin
            r = x - a;
            c = x >= a;
            dc = x[3:0] >= a[3:0];
        end else if (op == OPC_RRC) begin
            r = {c, x[7:1]};
            c = x[0];
        end else if (op != OPC_SWAP) begin
            r = a ^ x;
        end
        if (op != OPC_RRC && op != OPC_SWAP) begin
            z = r == 8'h00;
        end
        apb(1'b1, OFS_INSTR, {8'h00, k, 5'h00, f, d, op});
        apb(1'b0, OFS_ACC, 32'h0000_0000);
        chk("acc", {24'h000000, to_f ? a : r}, rd);
        apb(1'b0, {FILE_SEL, f, 2'h0}, 32'h0000_0000);
        chk("file", {24'h000000, to_f ? r : v}, rd);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("flags", {29'h0, z, dc, c}, {29'h0, rd[2:0]});
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0018, rd);
        run_op(OPC_SUBLIT, 1'h0, 7'h00, 8'h20, 8'h21, 8'h00, 3'h0);
        run_op(OPC_SUBLIT, 1'h1, 7'h7F, 8'h55, 8'h55, 8'h11, 3'h0);
        run_op(OPC_SUBF, 1'h1, 7'h7F, 8'h00, 8'h0F, 8'h10, 3'h7);
        run_op(OPC_SUBF, 1'h0, 7'h05, 8'h00, 8'h01, 8'h00, 3'h0);
        run_op(OPC_RRC, 1'h0, 7'h03, 8'h00, 8'h00, 8'h81, 3'h4);
        run_op(OPC_RRC, 1'h1, 7'h00, 8'h00, 8'h00, 8'h02, 3'h1);
        run_op(OPC_SWAP, 1'h1, 7'h7F, 8'h00, 8'hC3, 8'hA5, 3'h7);
        run_op(OPC_SWAP, 1'h0, 7'h09, 8'h00, 8'h00, 8'h0F, 3'h0);
        run_op(OPC_XORLIT, 1'h0, 7'h00, 8'h5A, 8'h5A, 8'h00, 3'h3);
        run_op(OPC_XORF, 1'h1, 7'h40, 8'h00, 8'hF0, 8'h0F, 3'h4);
        run_op(OPC_XORF, 1'h0, 7'h41, 8'h00, 8'h33, 8'h33, 3'h3);
        // let the prescaler wrap so the counter is nonzero before sleep
        repeat (300) @(posedge pclk);
        apb(1'b0, OFS_WDOG, 32'h0000_0000);
        chk("wdog run", 32'h1, {31'h0, rd[7:0] != 8'h00});
        apb(1'b1, OFS_INSTR, {29'h00000000, OPC_SLEEP});
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("sleep flags", 32'h6, {29'h0, rd[5:3]});
        chk("osc", 32'h0, {31'h0, osc_run});
        apb(1'b0, OFS_WDOG, 32'h0000_0000);
        chk("wdog", 32'h0, {16'h0000, rd[15:0]});
        apb(1'b1, OFS_INSTR, {8'h00, 8'hFF, 13'h0000, OPC_XORLIT});
        chk("refused", 32'h1, {31'h0, err});
        apb(1'b0, OFS_ACC, 32'h0000_0000);
        chk("acc asleep", 32'h0, rd);
        apb(1'b1, OFS_WAKE, 32'h0000_0001);
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk("awake", 32'h1, {30'h0, sleep_active, osc_run});
        chk("unmapped", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        end_of_test();
    end
endmodule // tb_mcu_alu
`default_nettype wire
